// *** logic/pdc_defs.vh ***
// register indices, address ranges, field positions, alu function codes and reset values for the cell
`ifndef PDC_DEFS_VH
`define PDC_DEFS_VH

// working registers and cell control on the system bus
`define PDC_REG_A0 8'h00
`define PDC_REG_A1 8'h01
`define PDC_REG_D0 8'h02
`define PDC_REG_D1 8'h03
`define PDC_REG_F0 8'h04
`define PDC_REG_F1 8'h05
`define PDC_REG_CTL 8'h06
`define PDC_REG_STAT 8'h07
`define PDC_REG_DPCFG 8'h08
`define PDC_REG_CMASK 8'h09
`define PDC_REG_POLY 8'h0a
`define PDC_REG_MSB 8'h0b
`define PDC_REG_OSEL0 8'h0c
`define PDC_REG_OSEL1 8'h0d
`define PDC_REG_OSEL2 8'h0e
`define PDC_REG_OMASK 8'h0f
// configuration memory bytes 0x10..0x1f, array config 0x40..0x5f and 0x60..0x7f
`define PDC_CRAM_HI 4'h1
`define PDC_PLD0_HI 3'h2
`define PDC_PLD1_HI 3'h3

// dpcfg fields
`define PDC_DPCFG_F0OUT 0
`define PDC_DPCFG_F1OUT 1
`define PDC_DPCFG_CHAIN 2
// msb register fields
`define PDC_MSB_CMP1SEL 3

// configuration word fields
`define PDC_CW_FUNC 2:0
`define PDC_CW_SRCA 3
`define PDC_CW_SRCB 5:4
`define PDC_CW_SHIFT 7:6
`define PDC_CW_DEST 9:8
`define PDC_CW_CIREG 10
`define PDC_CW_SIREG 11
`define PDC_CW_F0EN 12
`define PDC_CW_F1EN 13
`define PDC_CW_MASK 14
`define PDC_CW_FTOA 15

// alu functions
`define PDC_FN_PASS 3'h0
`define PDC_FN_INC 3'h1
`define PDC_FN_DEC 3'h2
`define PDC_FN_ADD 3'h3
`define PDC_FN_SUB 3'h4
`define PDC_FN_AND 3'h5
`define PDC_FN_OR 3'h6
`define PDC_FN_XOR 3'h7

// reset values
`define PDC_MSB_RST 8'h07
`define PDC_MASK_RST 8'hff

`endif

// *** logic/pdc_cell.v ***
// programmable digital cell: two sum-of-products arrays, fifos and an 8-bit datapath
// Function
// RULE_01: each array takes twelve routing inputs into eight product terms
// RULE_02: a term ANDs one to twelve inputs, each true or complemented
// RULE_03: each output ORs up to eight terms, same OR width everywhere
// RULE_04: each array output is selectable registered or combinational
// RULE_05: the cell holds exactly two arrays and one datapath
// RULE_06: 8-bit alu does one operation per clock, plus compares and conditions
// RULE_07: accumulators, data registers and fifos are bus readable and writable
// RULE_08: accumulators are alu sources, sinks and compare inputs; data regs only sources
// RULE_09: two four-byte fifos load regs or capture accumulator or alu values
// RULE_10: each fifo is independently an input or an output buffer
// RULE_11: fifo status can be selected onto the datapath outputs
// RULE_12: eight-entry 16-bit configuration memory, one datapath function each
// RULE_13: routing address picks the active entry, may change every cycle
// RULE_14: alu does inc, dec, add, sub, and, or, xor, pass
// RULE_15: shift left, shift right, swap and OR mask apply after any operation
// RULE_16: two masked comparators over accumulators and data registers
// RULE_17: zero, all-ones and overflow detection
// RULE_18: selected conditions drive the six datapath outputs
// RULE_19: programmable msb position for arithmetic and shifts
// RULE_20: one crc or pseudo random step per cycle with programmable polynomial
// RULE_21: carry, shift data and compares chain to neighbouring cells
// RULE_22: carry and shift-out are registered and selectable later
// RULE_23: status is read-only routing state; control bits drive routing
// RULE_24: fifos flag empty and full; bad push or pop changes nothing
// RULE_25: reset clears registered array outputs, fifos and config address
`timescale 1ns/1ps
`include "pdc_defs.vh"

// one sum-of-products array with its own configuration store
module pdc_pld #(
  parameter NIN = 12,
  parameter NPT = 8,
  parameter NOUT = 4
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // routing side
  input wire [NIN-1:0] pin,
  output reg [NOUT-1:0] pout,
  // configuration write port
  input wire cfg_we,
  input wire [4:0] cfg_addr,
  input wire [7:0] cfg_wdata
);
  localparam NB = (2*NIN+7)/8;
  reg [8*NB-1:0] term_q [0:NPT-1];
  reg [NPT-1:0] or_q [0:NOUT-1];
  reg [NOUT-1:0] regsel_q;
  reg [NOUT-1:0] state_q;
  reg [NPT-1:0] pt;
  reg [NOUT-1:0] sop;
  integer t, k;
  // separate loop indices for the combinational block, so no variable has two drivers
  integer ct, ci, ck;

  // configuration writes: term bytes, then or masks, then register select
  always @(posedge clk) begin
    if (rst) begin
      for (t = 0; t < NPT; t = t + 1) term_q[t] <= {8*NB{1'b0}};
      for (t = 0; t < NOUT; t = t + 1) or_q[t] <= {NPT{1'b0}};
      regsel_q <= {NOUT{1'b0}};
    end else if (cfg_we) begin
      for (t = 0; t < NPT; t = t + 1) begin
        for (k = 0; k < NB; k = k + 1) begin
          if ({27'h0, cfg_addr} == t*NB + k) term_q[t][8*k +: 8] <= cfg_wdata;
        end
      end
      for (t = 0; t < NOUT; t = t + 1) begin
        if ({27'h0, cfg_addr} == NPT*NB + t) or_q[t] <= cfg_wdata[NPT-1:0];
      end
      if ({27'h0, cfg_addr} == NPT*NB + NOUT) regsel_q <= cfg_wdata[NOUT-1:0];
    end
  end

  // product terms; a term that uses no input stays low
  always @* begin
    for (ct = 0; ct < NPT; ct = ct + 1) begin
      pt[ct] = |term_q[ct][2*NIN-1:0]; // RULE_02
      for (ci = 0; ci < NIN; ci = ci + 1) begin
        if (term_q[ct][2*ci] && !pin[ci]) pt[ct] = 1'b0; // RULE_01 RULE_02
        if (term_q[ct][2*ci+1] && pin[ci]) pt[ct] = 1'b0; // RULE_02
      end
    end
    for (ck = 0; ck < NOUT; ck = ck + 1) begin
      sop[ck] = |(pt & or_q[ck]); // RULE_03
      pout[ck] = regsel_q[ck] ? state_q[ck] : sop[ck]; // RULE_04
    end
  end

  // registered outputs clear on reset
  always @(posedge clk) begin
    if (rst) state_q <= {NOUT{1'b0}}; // RULE_25
    else state_q <= sop; // RULE_04
  end
endmodule // pdc_pld

// small circular fifo with honest empty and full
module pdc_fifo #(
  parameter W = 8,
  parameter D = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst,
  input wire push,
  input wire [W-1:0] din,
  input wire pop,
  output wire [W-1:0] dout,
  output wire empty,
  output wire full
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire do_push = push && !full; // RULE_24
  wire do_pop = pop && !empty; // RULE_24
  localparam [AW:0] DEPTH = D;

  assign dout = mem[rp_q];
  assign empty = (cnt_q == {(AW+1){1'b0}}); // RULE_24
  assign full = (cnt_q == DEPTH); // RULE_24

  // pointers and count
  always @(posedge clk) begin
    if (rst) begin
      wp_q <= {AW{1'b0}}; // RULE_25
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (do_push) mem[wp_q] <= din;
      if (do_push) wp_q <= wp_q + 1'b1;
      if (do_pop) rp_q <= rp_q + 1'b1;
      if (do_push && !do_pop) cnt_q <= cnt_q + 1'b1;
      else if (do_pop && !do_push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // pdc_fifo

// the cell: two arrays, datapath, fifos, status and control
module pdc_cell (
  // clock and reset
  input wire clk,
  input wire rst,
  // system bus
  input wire [7:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata_q,
  // array routing
  input wire [11:0] pld_in_0,
  input wire [11:0] pld_in_1,
  output wire [3:0] pld_out_0,
  output wire [3:0] pld_out_1,
  // datapath routing
  input wire [2:0] dp_cfg_addr,
  input wire dp_si,
  output reg [5:0] dp_out_q,
  // chaining from and to neighbours
  input wire chain_ci,
  input wire chain_si,
  input wire chain_eq,
  input wire chain_lt,
  output reg chain_co_q,
  output reg chain_so_q,
  output reg chain_eq_q,
  output reg chain_lt_q,
  // status and control routing
  input wire [7:0] status_in,
  output reg [7:0] ctl_out_q
);
  reg [7:0] a0_q, a1_q, d0_q, d1_q;
  reg [7:0] dpcfg_q, cmask_q, poly_q, msb_q, omask_q;
  reg [23:0] osel_q;
  reg [15:0] cram [0:7];
  reg [2:0] cfg_addr_q;
  reg co_q, so_q, ov_q;
  reg [8:0] sum9;
  reg [7:0] sh, rd_d;
  reg so;
  integer j, m;

  // two arrays share the bus write port
  wire pld0_we = bus_wr && (bus_addr[7:5] == `PDC_PLD0_HI);
  wire pld1_we = bus_wr && (bus_addr[7:5] == `PDC_PLD1_HI);
  pdc_pld #(.NIN(12), .NPT(8), .NOUT(4)) u_pld0 ( // RULE_05
    .clk(clk), .rst(rst), .pin(pld_in_0), .pout(pld_out_0),
    .cfg_we(pld0_we), .cfg_addr(bus_addr[4:0]), .cfg_wdata(bus_wdata));
  pdc_pld #(.NIN(12), .NPT(8), .NOUT(4)) u_pld1 ( // RULE_05
    .clk(clk), .rst(rst), .pin(pld_in_1), .pout(pld_out_1),
    .cfg_we(pld1_we), .cfg_addr(bus_addr[4:0]), .cfg_wdata(bus_wdata));

  // active configuration word and its fields
  wire [15:0] cw = cram[cfg_addr_q]; // RULE_13
  wire [2:0] fn = cw[`PDC_CW_FUNC];
  wire [2:0] msb = msb_q[2:0];
  wire [7:0] wm = 8'hff >> (3'h7 - msb); // RULE_19
  wire chain_en = dpcfg_q[`PDC_DPCFG_CHAIN];
  wire f0_out = dpcfg_q[`PDC_DPCFG_F0OUT];
  wire f1_out = dpcfg_q[`PDC_DPCFG_F1OUT];

  // operand selection: a from accumulators, b from data regs or accumulators
  wire [7:0] pa = (cw[`PDC_CW_SRCA] ? a1_q : a0_q) & wm; // RULE_08
  reg [7:0] pb;
  always @* begin
    case (cw[`PDC_CW_SRCB])
      2'h0: pb = d0_q & wm; // RULE_08
      2'h1: pb = d1_q & wm;
      2'h2: pb = a0_q & wm;
      default: pb = a1_q & wm;
    endcase
  end

  // carry and serial input: registered, chained or plain
  wire cin = cw[`PDC_CW_CIREG] ? co_q : (chain_en & chain_ci); // RULE_22 RULE_21
  wire si = cw[`PDC_CW_SIREG] ? so_q : (chain_en ? chain_si : dp_si); // RULE_22 RULE_21

  // alu: one operation per clock
  always @* begin
    case (fn)
      `PDC_FN_INC: sum9 = {1'b0, pa} + 9'h001; // RULE_14
      `PDC_FN_DEC: sum9 = {1'b0, pa} - 9'h001;
      `PDC_FN_ADD: sum9 = {1'b0, pa} + {1'b0, pb} + {8'h00, cin}; // RULE_06
      `PDC_FN_SUB: sum9 = {1'b0, pa} - {1'b0, pb} - {8'h00, cin};
      `PDC_FN_AND: sum9 = {1'b0, pa & pb};
      `PDC_FN_OR: sum9 = {1'b0, pa | pb};
      `PDC_FN_XOR: sum9 = {1'b0, pa ^ pb};
      default: sum9 = {1'b0, pa}; // pass
    endcase
  end
  wire [7:0] alu = sum9[7:0] & wm;
  wire arith = (fn == `PDC_FN_INC) || (fn == `PDC_FN_DEC) ||
               (fn == `PDC_FN_ADD) || (fn == `PDC_FN_SUB);
  wire carry = sum9[{1'b0, msb} + 4'h1]; // RULE_19

  // signed overflow at the programmed msb
  wire sa = pa[msb];
  wire sb = pb[msb];
  wire sr = alu[msb];
  wire ov = ((fn == `PDC_FN_ADD) && (sa == sb) && (sr != sa)) || // RULE_17
            ((fn == `PDC_FN_SUB) && (sa != sb) && (sr != sa));

  // shifter after any alu function, msb aware
  always @* begin
    case (cw[`PDC_CW_SHIFT])
      2'h1: begin
        sh = ((alu << 1) | {7'h00, si}) & wm; // RULE_15
        so = alu[msb];
      end
      2'h2: begin
        sh = (alu >> 1) | ({7'h00, si} << msb); // RULE_15 RULE_19
        so = alu[0];
      end
      2'h3: begin
        sh = {alu[3:0], alu[7:4]} & wm; // RULE_15
        so = 1'b0;
      end
      default: begin
        sh = alu;
        so = 1'b0;
      end
    endcase
  end
  wire [7:0] res = (cw[`PDC_CW_MASK] ? (sh | omask_q) : sh) & wm; // RULE_15

  // crc or pseudo random step on the source accumulator
  wire fb = pa[msb] ^ si; // RULE_20
  wire [7:0] crc = ((pa << 1) ^ (fb ? poly_q : 8'h00)) & wm; // RULE_20

  // fifos: input mode fed by bus, output mode fed by datapath
  wire bus_f0 = (bus_addr == `PDC_REG_F0);
  wire bus_f1 = (bus_addr == `PDC_REG_F1);
  wire [7:0] f0_dout, f1_dout;
  wire f0_empty, f0_full, f1_empty, f1_full;
  wire f0_push = f0_out ? cw[`PDC_CW_F0EN] : (bus_wr && bus_f0); // RULE_10
  wire f0_pop = f0_out ? (bus_rd && bus_f0) : cw[`PDC_CW_F0EN]; // RULE_10
  wire f1_push = f1_out ? cw[`PDC_CW_F1EN] : (bus_wr && bus_f1); // RULE_10
  wire f1_pop = f1_out ? (bus_rd && bus_f1) : cw[`PDC_CW_F1EN]; // RULE_10
  pdc_fifo #(.W(8), .D(4), .AW(2)) u_fifo0 ( // RULE_09
    .clk(clk), .rst(rst), .push(f0_push), .din(f0_out ? res : bus_wdata),
    .pop(f0_pop), .dout(f0_dout), .empty(f0_empty), .full(f0_full));
  pdc_fifo #(.W(8), .D(4), .AW(2)) u_fifo1 ( // RULE_09
    .clk(clk), .rst(rst), .push(f1_push), .din(f1_out ? res : bus_wdata),
    .pop(f1_pop), .dout(f1_dout), .empty(f1_empty), .full(f1_full));
  wire f0_load = !f0_out && cw[`PDC_CW_F0EN] && !f0_empty;
  wire f1_load = !f1_out && cw[`PDC_CW_F1EN] && !f1_empty;

  // two masked comparators
  wire [7:0] cm = cmask_q & wm;
  wire [7:0] c1a = msb_q[`PDC_MSB_CMP1SEL] ? a0_q : a1_q;
  wire [7:0] c1b = msb_q[`PDC_MSB_CMP1SEL] ? a1_q : d1_q;
  wire ce0l = ((a0_q & cm) == (d0_q & cm)); // RULE_16
  wire cl0l = ((a0_q & cm) < (d0_q & cm)); // RULE_16
  wire ce1 = ((c1a & cm) == (c1b & cm)); // RULE_16
  wire cl1 = ((c1a & cm) < (c1b & cm)); // RULE_16
  wire ce0 = ce0l && (!chain_en || chain_eq); // RULE_21
  wire cl0 = cl0l || (ce0l && chain_en && chain_lt); // RULE_21

  // condition vector for output selection
  wire [15:0] cond = {1'b0, f1_full, f1_empty, f0_full, f0_empty, // RULE_11
                      so_q, co_q, ov_q,
                      (a1_q & wm) == wm, (a0_q & wm) == wm, // RULE_17
                      (a1_q & wm) == 8'h00, (a0_q & wm) == 8'h00, // RULE_17
                      cl1, ce1, cl0, ce0};

  // configuration address register
  always @(posedge clk) begin
    if (rst) cfg_addr_q <= 3'h0; // RULE_25
    else cfg_addr_q <= dp_cfg_addr; // RULE_13
  end

  // datapath outputs and chain outputs
  always @(posedge clk) begin
    if (rst) begin
      dp_out_q <= 6'h00;
      chain_co_q <= 1'b0;
      chain_so_q <= 1'b0;
      chain_eq_q <= 1'b0;
      chain_lt_q <= 1'b0;
    end else begin
      for (j = 0; j < 6; j = j + 1) dp_out_q[j] <= cond[osel_q[4*j +: 4]]; // RULE_18
      chain_co_q <= carry; // RULE_21
      chain_so_q <= so;
      chain_eq_q <= ce0;
      chain_lt_q <= cl0;
    end
  end

  // working registers: datapath updates, bus writes win
  always @(posedge clk) begin
    if (rst) begin
      a0_q <= 8'h00;
      a1_q <= 8'h00;
      d0_q <= 8'h00;
      d1_q <= 8'h00;
      co_q <= 1'b0;
      so_q <= 1'b0;
      ov_q <= 1'b0;
    end else begin
      if (arith) co_q <= carry; // RULE_22
      if (cw[`PDC_CW_SHIFT] != 2'h0) so_q <= so; // RULE_22
      ov_q <= ov; // RULE_17
      case (cw[`PDC_CW_DEST])
        2'h1: a0_q <= res; // RULE_08
        2'h2: a1_q <= res;
        2'h3: begin
          if (cw[`PDC_CW_SRCA]) a1_q <= crc; // RULE_20
          else a0_q <= crc;
        end
        default: ;
      endcase
      if (f0_load && cw[`PDC_CW_FTOA]) a0_q <= f0_dout; // RULE_09
      if (f0_load && !cw[`PDC_CW_FTOA]) d0_q <= f0_dout; // RULE_09
      if (f1_load && cw[`PDC_CW_FTOA]) a1_q <= f1_dout;
      if (f1_load && !cw[`PDC_CW_FTOA]) d1_q <= f1_dout;
      if (bus_wr && bus_addr == `PDC_REG_A0) a0_q <= bus_wdata; // RULE_07
      if (bus_wr && bus_addr == `PDC_REG_A1) a1_q <= bus_wdata;
      if (bus_wr && bus_addr == `PDC_REG_D0) d0_q <= bus_wdata;
      if (bus_wr && bus_addr == `PDC_REG_D1) d1_q <= bus_wdata;
    end
  end

  // setup registers and configuration memory
  always @(posedge clk) begin
    if (rst) begin
      ctl_out_q <= 8'h00;
      dpcfg_q <= 8'h00;
      cmask_q <= `PDC_MASK_RST;
      poly_q <= 8'h00;
      msb_q <= `PDC_MSB_RST;
      omask_q <= 8'h00;
      osel_q <= 24'h000000;
      for (m = 0; m < 8; m = m + 1) cram[m] <= 16'h0000;
    end else if (bus_wr) begin
      case (bus_addr)
        `PDC_REG_CTL: ctl_out_q <= bus_wdata; // RULE_23
        `PDC_REG_DPCFG: dpcfg_q <= bus_wdata;
        `PDC_REG_CMASK: cmask_q <= bus_wdata;
        `PDC_REG_POLY: poly_q <= bus_wdata;
        `PDC_REG_MSB: msb_q <= bus_wdata;
        `PDC_REG_OMASK: omask_q <= bus_wdata;
        `PDC_REG_OSEL0: osel_q[7:0] <= bus_wdata;
        `PDC_REG_OSEL1: osel_q[15:8] <= bus_wdata;
        `PDC_REG_OSEL2: osel_q[23:16] <= bus_wdata;
        default: ;
      endcase
      if (bus_addr[7:4] == `PDC_CRAM_HI) begin // RULE_12
        if (bus_addr[0]) cram[bus_addr[3:1]][15:8] <= bus_wdata;
        else cram[bus_addr[3:1]][7:0] <= bus_wdata;
      end
    end
  end

  // bus read mux; unmapped and write-only locations read zero
  always @* begin
    rd_d = 8'h00;
    case (bus_addr)
      `PDC_REG_A0: rd_d = a0_q; // RULE_07
      `PDC_REG_A1: rd_d = a1_q;
      `PDC_REG_D0: rd_d = d0_q;
      `PDC_REG_D1: rd_d = d1_q;
      `PDC_REG_F0: rd_d = f0_dout; // RULE_07
      `PDC_REG_F1: rd_d = f1_dout;
      `PDC_REG_CTL: rd_d = ctl_out_q;
      `PDC_REG_STAT: rd_d = status_in; // RULE_23
      `PDC_REG_DPCFG: rd_d = dpcfg_q;
      `PDC_REG_CMASK: rd_d = cmask_q;
      `PDC_REG_POLY: rd_d = poly_q;
      `PDC_REG_MSB: rd_d = msb_q;
      `PDC_REG_OSEL0: rd_d = osel_q[7:0];
      `PDC_REG_OSEL1: rd_d = osel_q[15:8];
      `PDC_REG_OSEL2: rd_d = osel_q[23:16];
      `PDC_REG_OMASK: rd_d = omask_q;
      default: begin
        if (bus_addr[7:4] == `PDC_CRAM_HI)
          rd_d = bus_addr[0] ? cram[bus_addr[3:1]][15:8] : cram[bus_addr[3:1]][7:0];
      end
    endcase
  end

  // read data registered one cycle after the strobe
  always @(posedge clk) begin
    if (rst) bus_rdata_q <= 8'h00;
    else if (bus_rd) bus_rdata_q <= rd_d;
  end
endmodule // pdc_cell

// *** bench/pdc_route_model.sv ***
// routing-side neighbour model: status lines, serial input and chain inputs of the cell
`timescale 1ns/1ps
module pdc_route_model (
  // clock
  input logic clk,
  // lines towards the cell
  output logic [7:0] status_in,
  output logic dp_si,
  output logic chain_ci,
  output logic chain_si,
  output logic chain_eq,
  output logic chain_lt
);
  // chaining stays off in the cell, so the neighbour lines rest low
  assign dp_si = 1'b0;
  assign chain_ci = 1'b0;
  assign chain_si = 1'b0;
  assign chain_eq = 1'b0;
  assign chain_lt = 1'b0;
  // status lines move every cycle so that a stale read is caught
  initial status_in = 8'h3b;
  always @(posedge clk) begin
    status_in <= status_in + 8'h25;
  end
endmodule // pdc_route_model

// *** bench/pdc_cell_props.sv ***
// concurrent checks on the ports of the programmable digital cell
`timescale 1ns/1ps
module pdc_cell_props (
  // clock and reset
  input logic clk,
  input logic rst,
  // system bus
  input logic [7:0] bus_addr,
  input logic bus_wr,
  input logic bus_rd,
  input logic [7:0] bus_wdata,
  input logic [7:0] bus_rdata_q,
  // routing outputs and status input
  input logic [3:0] pld_out_0,
  input logic [3:0] pld_out_1,
  input logic [5:0] dp_out_q,
  input logic chain_co_q,
  input logic chain_so_q,
  input logic chain_eq_q,
  input logic chain_lt_q,
  input logic [7:0] status_in,
  input logic [7:0] ctl_out_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_rd_unmapped: assert property (bus_rd && bus_addr[7:5] == 3'h1 |=> bus_rdata_q == 8'h00)
    else $error("unmapped read gave nonzero data");
  chk_array_wo: assert property (bus_rd && bus_addr[7:6] == 2'h1 |=> bus_rdata_q == 8'h00)
    else $error("array configuration read gave nonzero data");
  chk_rd_hold: assert property (!bus_rd |=> $stable(bus_rdata_q))
    else $error("read data moved without a read");
  chk_stat_read: assert property (bus_rd && bus_addr == 8'h07 |=> bus_rdata_q == $past(status_in))
    else $error("status read does not show the routing lines");
  chk_ctl_write: assert property (bus_wr && bus_addr == 8'h06 |=> ctl_out_q == $past(bus_wdata))
    else $error("control write did not reach the routing");
  chk_ctl_hold: assert property (!(bus_wr && bus_addr == 8'h06) |=> $stable(ctl_out_q))
    else $error("control bits moved without a write");
  chk_data_rdback: assert property (bus_wr && bus_addr == 8'h02 ##2 bus_rd && bus_addr == 8'h02
    |=> bus_rdata_q == $past(bus_wdata, 3))
    else $error("data register read back differs");
  chk_cfg_rdback: assert property (bus_wr && bus_addr[7:4] == 4'h1
    ##2 bus_rd && bus_addr == $past(bus_addr, 2) |=> bus_rdata_q == $past(bus_wdata, 3))
    else $error("configuration memory read back differs");
  chk_reset_clear: assert property ($fell(rst) |-> {dp_out_q, chain_co_q, chain_so_q,
    chain_eq_q, chain_lt_q, ctl_out_q, bus_rdata_q, pld_out_0, pld_out_1} == 32'h0)
    else $error("outputs not cleared by reset");
endmodule // pdc_cell_props

bind pdc_cell pdc_cell_props pdc_cell_props_i (.clk(clk), .rst(rst), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
  .pld_out_0(pld_out_0), .pld_out_1(pld_out_1), .dp_out_q(dp_out_q), .chain_co_q(chain_co_q),
  .chain_so_q(chain_so_q), .chain_eq_q(chain_eq_q), .chain_lt_q(chain_lt_q),
  .status_in(status_in), .ctl_out_q(ctl_out_q));

// *** bench/tb.sv ***
// self-checking bench for the programmable digital cell
`timescale 1ns/1ps
`include "pdc_defs.vh"
module tb;
  // cell ports
  logic clk, rst, bus_wr, bus_rd, dp_si, chain_ci, chain_si, chain_eq, chain_lt;
  logic chain_co_q, chain_so_q, chain_eq_q, chain_lt_q;
  logic [7:0] bus_addr, bus_wdata, bus_rdata_q, status_in, ctl_out_q;
  logic [11:0] pld_in_0, pld_in_1;
  logic [3:0] pld_out_0, pld_out_1;
  logic [2:0] dp_cfg_addr;
  logic [5:0] dp_out_q;
  int n_errors, n_checks;
  // alu results for a0=5c, d0=37: eight functions, two shifts and a swap, OR mask 03
  logic [7:0] alu_tab [12] = '{8'h5c, 8'h5d, 8'h5b, 8'h93, 8'h25, 8'h14, 8'h7f, 8'h6b,
    8'hb8, 8'h2e, 8'hc5, 8'h5f};

  pdc_cell pdc_cell_i (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .pld_in_0(pld_in_0),
    .pld_in_1(pld_in_1), .pld_out_0(pld_out_0), .pld_out_1(pld_out_1),
    .dp_cfg_addr(dp_cfg_addr), .dp_si(dp_si), .dp_out_q(dp_out_q), .chain_ci(chain_ci),
    .chain_si(chain_si), .chain_eq(chain_eq), .chain_lt(chain_lt), .chain_co_q(chain_co_q),
    .chain_so_q(chain_so_q), .chain_eq_q(chain_eq_q), .chain_lt_q(chain_lt_q),
    .status_in(status_in), .ctl_out_q(ctl_out_q));
  pdc_route_model pdc_route_model_i (.clk(clk), .status_in(status_in), .dp_si(dp_si),
    .chain_ci(chain_ci), .chain_si(chain_si), .chain_eq(chain_eq), .chain_lt(chain_lt));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bus cycles start at a falling edge and end at the next one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    cmp(what, exp, bus_rdata_q);
    @(negedge clk);
  endtask
  task automatic cfg(input int i, input logic [15:0] w);
    wr(8'h10 + 8'(2 * i), w[7:0]);
    wr(8'h11 + 8'(2 * i), w[15:8]);
  endtask
  // hold entry i for n cycles, then let the last update land
  task automatic run(input logic [2:0] i, input int n);
    dp_cfg_addr = i;
    repeat (n) @(negedge clk);
    dp_cfg_addr = 3'h0;
    repeat (2) @(negedge clk);
  endtask
  task automatic do_reset;
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
  endtask

  task automatic t_regs;
    rdc("cmask reset", `PDC_REG_CMASK, `PDC_MASK_RST);
    rdc("msb reset", `PDC_REG_MSB, `PDC_MSB_RST);
    wr(`PDC_REG_A0, 8'ha5);
    rdc("a0", `PDC_REG_A0, 8'ha5);
    wr(`PDC_REG_A1, 8'h5a);
    rdc("a1", `PDC_REG_A1, 8'h5a);
    wr(`PDC_REG_D0, 8'h3c);
    rdc("d0", `PDC_REG_D0, 8'h3c);
    wr(`PDC_REG_D1, 8'hc3);
    rdc("d1", `PDC_REG_D1, 8'hc3);
    wr(8'h13, 8'h77);
    rdc("config byte", 8'h13, 8'h77);
    wr(`PDC_REG_CTL, 8'h96);
    cmp("ctl out", 8'h96, ctl_out_q);
    wr(`PDC_REG_STAT, 8'hff);
    rdc("stat", `PDC_REG_STAT, status_in);
    rdc("unmapped", 8'h20, 8'h00);
    rdc("array read", 8'h40, 8'h00);
  endtask

  // every function and every post-alu stage, a0 op d0 into a1
  task automatic t_alu;
    logic [15:0] w;
    wr(`PDC_REG_OMASK, 8'h03);
    for (int k = 0; k < 12; k++) begin
      w = (k < 8) ? 16'h0200 | 16'(k) : (k < 11) ? 16'h0200 | (16'(k - 7) << 6) : 16'h4200;
      wr(`PDC_REG_A0, 8'h5c);
      wr(`PDC_REG_D0, 8'h37);
      cfg(1, w);
      run(3'h1, 1);
      rdc("alu result", `PDC_REG_A1, alu_tab[k]);
    end
  endtask

  // f0 as input buffer into d0, f1 as output buffer from a0
  task automatic t_fifo;
    wr(`PDC_REG_OSEL0, 8'hbc);
    repeat (2) @(negedge clk);
    cmp("f0 flags idle", 8'h02, {2'h0, dp_out_q} & 8'h03);
    for (int k = 0; k < 5; k++) wr(`PDC_REG_F0, 8'h10 + 8'(k));
    repeat (2) @(negedge clk);
    cmp("f0 flags full", 8'h01, {2'h0, dp_out_q} & 8'h03);
    rdc("f0 head", `PDC_REG_F0, 8'h10);
    cfg(2, 16'h1000);
    run(3'h2, 1);
    rdc("d0 load", `PDC_REG_D0, 8'h10);
    rdc("f0 next", `PDC_REG_F0, 8'h11);
    run(3'h2, 4);
    rdc("d0 after drain", `PDC_REG_D0, 8'h13);
    cmp("f0 flags drained", 8'h02, {2'h0, dp_out_q} & 8'h03);
    wr(`PDC_REG_DPCFG, 8'h02);
    wr(`PDC_REG_A0, 8'h4e);
    cfg(3, 16'h2000);
    run(3'h3, 1);
    wr(`PDC_REG_F1, 8'h99);
    rdc("f1 pop", `PDC_REG_F1, 8'h4e);
    wr(`PDC_REG_OSEL1, 8'h0d);
    repeat (2) @(negedge clk);
    cmp("f1 empty", 8'h04, {2'h0, dp_out_q} & 8'h04);
  endtask

  // out0 = in0, out1 = not in1, then out0 registered; array1 out0 = in0 only, combinational
  task automatic t_pld;
    wr(8'h40, 8'h01);
    wr(8'h43, 8'h08);
    wr(8'h58, 8'h01);
    wr(8'h59, 8'h02);
    pld_in_0 = 12'h001;
    #1 cmp("array0 comb", 8'h03, {4'h0, pld_out_0});
    pld_in_0 = 12'h002;
    #1 cmp("array0 comb low", 8'h00, {4'h0, pld_out_0});
    wr(8'h5c, 8'h01);
    pld_in_0 = 12'h001;
    #1 cmp("array0 reg before", 8'h02, {4'h0, pld_out_0});
    @(negedge clk);
    cmp("array0 reg after", 8'h03, {4'h0, pld_out_0});
    wr(8'h60, 8'h01);
    wr(8'h78, 8'h01);
    pld_in_1 = 12'h001;
    #1 cmp("array1 comb", 8'h01, {4'h0, pld_out_1});
  endtask

  // reset in mid-run clears array0 output and the f0 fifo
  task automatic t_reset;
    wr(`PDC_REG_F0, 8'h44);
    do_reset;
    #1 cmp("array0 cleared", 8'h00, {4'h0, pld_out_0});
    wr(`PDC_REG_OSEL0, 8'hbc);
    repeat (2) @(negedge clk);
    cmp("f0 empty after reset", 8'h02, {2'h0, dp_out_q} & 8'h03);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    n_errors = 0;
    n_checks = 0;
    rst = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    pld_in_0 = 12'h000;
    pld_in_1 = 12'h000;
    dp_cfg_addr = 3'h0;
    @(negedge clk);
    do_reset;
    t_regs;
    t_alu;
    t_fifo;
    t_pld;
    t_reset;
    summarize;
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    summarize;
  end
endmodule // tb
